// [src/lpm_pkg.sv]
/*
 * Shared constants for the low-power mode controller: register offsets,
 * field positions, reset values, mode codes and output vector indices.
 * Assumes a 32-bit register port with byte offsets.
 */
package lpm_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_PORTION_BIT = 3;
    localparam int STATE_BYPASS_BIT = 4;
    localparam int STATE_CONT_BIT = 5;
    localparam logic [2:0] TARGET_RESET = 3'h0;
    localparam logic PORTION_RESET = 1'b0;
    localparam logic [4:0] WAKE_EN_RESET = 5'h00;
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;
    localparam logic [15:0] DOMAIN_RESET = 16'h62e4;

    // ************************************************************
    // Wake sources and events
    // ************************************************************
    localparam int NWAKE = 5;
    localparam int WAKE_PIN = 0;
    localparam int WAKE_TIMER = 1;
    localparam int WAKE_CAL = 2;
    localparam int WAKE_COMPARE = 3;
    localparam int WAKE_RADIO = 4;
    localparam int NEV = 3;
    localparam int EV_ENTER = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_REFUSE = 2;

    // ************************************************************
    // Power modes
    // ************************************************************
    typedef enum logic [3:0] {
        MODE_LP_RUN = 4'h0,
        MODE_LP_WAIT = 4'h1,
        MODE_LP_STOP = 4'h2,
        MODE_LEAK3 = 4'h3,
        MODE_LEAK2 = 4'h4,
        MODE_DEEP3 = 4'h5,
        MODE_DEEP2 = 4'h6,
        MODE_DEEP1 = 4'h7,
        MODE_DEEP0B = 4'h8,
        MODE_DEEP0N = 4'h9
    } lpm_mode_t;
    localparam logic [3:0] TARGET_BASE = 4'h2;

    // ************************************************************
    // Domain control vector indices
    // ************************************************************
    localparam int ND = 16;
    localparam int D_CORE_SLEEP = 0;
    localparam int D_BIAS_OFF = 1;
    localparam int D_FLASH_LP = 2;
    localparam int D_LVD_ON = 3;
    localparam int D_WAKE_UNIT = 4;
    localparam int D_SRC_RUN = 5;
    localparam int D_SRAM_FULL = 6;
    localparam int D_SRAM_PART = 7;
    localparam int D_PORTION32K = 8;
    localparam int D_REGFILE = 9;
    localparam int D_RADIO_RET = 10;
    localparam int D_RADIO_GATE = 11;
    localparam int D_RADIO_DSM = 12;
    localparam int D_ANALOG = 13;
    localparam int D_BROWNOUT = 14;
    localparam int D_PAD_HOLD = 15;

endpackage : lpm_pkg

// [src/lpm_sync.sv]
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes inputs are levels that stay stable for several clocks.
 */
`timescale 1ns/1ps
module lpm_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    if (WIDTH < 1) begin : g_chk
        $error("lpm_sync WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule : lpm_sync

// [src/lpm_domain_map.sv]
/*
 * Maps a power mode to the per-domain power, retention and gate controls.
 * Assumes the mode input is a registered value; output is combinational.
 */
`timescale 1ns/1ps
module lpm_domain_map (
    // Selection
    input wire lpm_pkg::lpm_mode_t mode,
    input wire logic continuous,
    input wire logic portion32k,
    // Controls
    output logic [lpm_pkg::ND-1:0] domain
);
    logic lp;
    logic leak;
    logic deep32;
    logic zero;

    always_comb begin
        lp = mode inside {lpm_pkg::MODE_LP_RUN, lpm_pkg::MODE_LP_WAIT, lpm_pkg::MODE_LP_STOP};
        leak = mode inside {lpm_pkg::MODE_LEAK3, lpm_pkg::MODE_LEAK2};
        deep32 = mode inside {lpm_pkg::MODE_DEEP3, lpm_pkg::MODE_DEEP2};
        zero = mode inside {lpm_pkg::MODE_DEEP0B, lpm_pkg::MODE_DEEP0N};
        domain = '0;
        domain[lpm_pkg::D_CORE_SLEEP] = mode != lpm_pkg::MODE_LP_RUN;
        domain[lpm_pkg::D_BIAS_OFF] = lp && continuous;
        domain[lpm_pkg::D_FLASH_LP] = lp;
        domain[lpm_pkg::D_LVD_ON] = 1'b0;
        domain[lpm_pkg::D_WAKE_UNIT] = !lp;
        domain[lpm_pkg::D_SRC_RUN] = !zero;
        domain[lpm_pkg::D_SRAM_FULL] = lp || mode == lpm_pkg::MODE_LEAK3
            || mode == lpm_pkg::MODE_DEEP3;
        domain[lpm_pkg::D_SRAM_PART] = lp || leak || deep32;
        domain[lpm_pkg::D_PORTION32K] = portion32k && (mode == lpm_pkg::MODE_LEAK2
            || mode == lpm_pkg::MODE_DEEP2);
        domain[lpm_pkg::D_REGFILE] = 1'b1;
        domain[lpm_pkg::D_RADIO_RET] = leak || deep32;
        domain[lpm_pkg::D_RADIO_GATE] = mode == lpm_pkg::MODE_DEEP1 || zero;
        domain[lpm_pkg::D_RADIO_DSM] = leak || deep32;
        domain[lpm_pkg::D_ANALOG] = !zero;
        domain[lpm_pkg::D_BROWNOUT] = mode != lpm_pkg::MODE_DEEP0N;
        domain[lpm_pkg::D_PAD_HOLD] = zero;
    end
endmodule : lpm_domain_map

// [src/lpm_controller.sv]
/*
 * Top of the low-power mode controller: register port, mode sequencer,
 * wake qualification, registered domain controls and interrupt logic.
 * Assumes sleep request, deep sleep select and core interrupt come from
 * logic on clk; wake sources and converter status come from pins.
 */
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module lpm_controller #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Core
    input wire logic sleepRequest,
    input wire logic deepSleepSelect,
    input wire logic coreInterrupt,
    // Pins
    input wire logic [lpm_pkg::NWAKE-1:0] wakeSource,
    input wire logic converterBypass,
    input wire logic converterContinuous,
    // Domain controls
    output logic coreSleep,
    output logic biasOff,
    output logic flashLowPower,
    output logic lowVoltageDetectOn,
    output logic wakeUnitOn,
    output logic wakeSourceRun,
    output logic sramFullPower,
    output logic sramPartialPower,
    output logic sramPortion32k,
    output logic regFilePower,
    output logic radioRetain,
    output logic radioPowerGate,
    output logic radioDeepSleepClock,
    output logic analogOn,
    output logic lowPowerOscOn,
    output logic brownOutOn,
    output logic padHold,
    // Wake and interrupt
    output logic wakeInterrupt,
    output logic wakeReset,
    output logic irq
);
    if (ADDR_W < 8) begin : g_chk
        $error("lpm_controller ADDR_W must be at least 8");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        lpm_pkg::lpm_mode_t mode;
        logic [lpm_pkg::ND-1:0] domain;
        logic [2:0] target;
        logic portion32k;
        logic [lpm_pkg::NWAKE-1:0] wakeEn;
        logic [lpm_pkg::NEV-1:0] irqStat;
        logic [lpm_pkg::NEV-1:0] irqEn;
        logic [31:0] rdata;
        logic wakeIntr;
        logic wakeRst;
        logic irq;
    } lpm_state_t;

    lpm_state_t st;
    lpm_state_t next_st;
    logic [lpm_pkg::NWAKE-1:0] wakeSync;
    logic bypassSync;
    logic contSync;
    logic [lpm_pkg::ND-1:0] domainMap;
    logic [lpm_pkg::NWAKE-1:0] wakeHit;

    // ************************************************************
    // Pin synchronisation and domain map
    // ************************************************************
    lpm_sync #(
        .WIDTH(lpm_pkg::NWAKE + 2)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({converterContinuous, converterBypass, wakeSource}),
        .q({contSync, bypassSync, wakeSync})
    );

    lpm_domain_map u_map (
        .mode(st.mode),
        .continuous(contSync),
        .portion32k(st.portion32k),
        .domain(domainMap)
    );

    // Wake sources usable in each mode
    function automatic logic [lpm_pkg::NWAKE-1:0] wakeAllowed(input lpm_pkg::lpm_mode_t m);
        case (m)
            lpm_pkg::MODE_LEAK3, lpm_pkg::MODE_LEAK2,
            lpm_pkg::MODE_DEEP3, lpm_pkg::MODE_DEEP2: begin
                wakeAllowed = 5'h1f;
            end
            lpm_pkg::MODE_DEEP1: begin
                wakeAllowed = 5'h0f;
            end
            lpm_pkg::MODE_DEEP0B, lpm_pkg::MODE_DEEP0N: begin
                wakeAllowed = 5'h01;
            end
            default: begin
                wakeAllowed = 5'h00;
            end
        endcase
    endfunction : wakeAllowed

    assign wakeHit = wakeSync & st.wakeEn & wakeAllowed(st.mode);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [lpm_pkg::NEV-1:0] ev;
        lpm_pkg::lpm_mode_t tgt;
        ev = '0;
        tgt = lpm_pkg::lpm_mode_t'(4'(st.target) + lpm_pkg::TARGET_BASE);
        next_st = st;
        next_st.wakeIntr = 1'b0;
        next_st.wakeRst = 1'b0;
        next_st.rdata = '0;
        next_st.domain = domainMap;
        case (st.mode)
            lpm_pkg::MODE_LP_RUN: begin
                if (sleepRequest) begin
                    if (!deepSleepSelect) begin
                        next_st.mode = lpm_pkg::MODE_LP_WAIT;
                        ev[lpm_pkg::EV_ENTER] = 1'b1;
                    end else if ((tgt == lpm_pkg::MODE_DEEP0B || tgt == lpm_pkg::MODE_DEEP0N)
                            && !bypassSync) begin
                        ev[lpm_pkg::EV_REFUSE] = 1'b1;
                    end else begin
                        next_st.mode = tgt;
                        ev[lpm_pkg::EV_ENTER] = 1'b1;
                    end
                end
            end
            lpm_pkg::MODE_LP_WAIT, lpm_pkg::MODE_LP_STOP: begin
                if (coreInterrupt) begin
                    next_st.mode = lpm_pkg::MODE_LP_RUN;
                    next_st.wakeIntr = 1'b1;
                    ev[lpm_pkg::EV_WAKE] = 1'b1;
                end
            end
            lpm_pkg::MODE_LEAK3, lpm_pkg::MODE_LEAK2: begin
                if (|wakeHit) begin
                    next_st.mode = lpm_pkg::MODE_LP_RUN;
                    next_st.wakeIntr = 1'b1;
                    ev[lpm_pkg::EV_WAKE] = 1'b1;
                end
            end
            lpm_pkg::MODE_DEEP3, lpm_pkg::MODE_DEEP2, lpm_pkg::MODE_DEEP1,
            lpm_pkg::MODE_DEEP0B, lpm_pkg::MODE_DEEP0N: begin
                if (|wakeHit) begin
                    next_st.mode = lpm_pkg::MODE_LP_RUN;
                    next_st.wakeRst = 1'b1;
                    ev[lpm_pkg::EV_WAKE] = 1'b1;
                end
            end
            default: begin
                next_st.mode = lpm_pkg::MODE_LP_RUN;
            end
        endcase

        // Register writes
        if (regWrite) begin
            case (regAddr[7:0])
                lpm_pkg::ADDR_CTRL: begin
                    next_st.target = regWdata[2:0];
                    next_st.portion32k = regWdata[lpm_pkg::CTRL_PORTION_BIT];
                end
                lpm_pkg::ADDR_WAKE_EN: begin
                    next_st.wakeEn = regWdata[lpm_pkg::NWAKE-1:0];
                end
                lpm_pkg::ADDR_IRQ_CLR: begin
                    next_st.irqStat = st.irqStat & ~regWdata[lpm_pkg::NEV-1:0];
                end
                lpm_pkg::ADDR_IRQ_EN: begin
                    next_st.irqEn = regWdata[lpm_pkg::NEV-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set beats clear
        next_st.irqStat = next_st.irqStat | ev;
        next_st.irq = |(next_st.irqStat & next_st.irqEn);

        // Register reads
        if (regRead) begin
            case (regAddr[7:0])
                lpm_pkg::ADDR_CTRL: begin
                    next_st.rdata = {28'h0000000, st.portion32k, st.target};
                end
                lpm_pkg::ADDR_WAKE_EN: begin
                    next_st.rdata = {27'h0000000, st.wakeEn};
                end
                lpm_pkg::ADDR_STATE: begin
                    next_st.rdata = {26'h0000000, contSync, bypassSync, st.mode};
                end
                lpm_pkg::ADDR_IRQ_STAT: begin
                    next_st.rdata = {29'h00000000, st.irqStat};
                end
                lpm_pkg::ADDR_IRQ_EN: begin
                    next_st.rdata = {29'h00000000, st.irqEn};
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.mode <= lpm_pkg::MODE_LP_RUN;
            st.domain <= lpm_pkg::DOMAIN_RESET;
            st.target <= lpm_pkg::TARGET_RESET;
            st.portion32k <= lpm_pkg::PORTION_RESET;
            st.wakeEn <= lpm_pkg::WAKE_EN_RESET;
            st.irqStat <= '0;
            st.irqEn <= lpm_pkg::IRQ_EN_RESET;
            st.rdata <= '0;
            st.wakeIntr <= 1'b0;
            st.wakeRst <= 1'b0;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign regRdata = st.rdata;
    assign coreSleep = st.domain[lpm_pkg::D_CORE_SLEEP];
    assign biasOff = st.domain[lpm_pkg::D_BIAS_OFF];
    assign flashLowPower = st.domain[lpm_pkg::D_FLASH_LP];
    assign lowVoltageDetectOn = st.domain[lpm_pkg::D_LVD_ON];
    assign wakeUnitOn = st.domain[lpm_pkg::D_WAKE_UNIT];
    assign wakeSourceRun = st.domain[lpm_pkg::D_SRC_RUN];
    assign sramFullPower = st.domain[lpm_pkg::D_SRAM_FULL];
    assign sramPartialPower = st.domain[lpm_pkg::D_SRAM_PART];
    assign sramPortion32k = st.domain[lpm_pkg::D_PORTION32K];
    assign regFilePower = st.domain[lpm_pkg::D_REGFILE];
    assign radioRetain = st.domain[lpm_pkg::D_RADIO_RET];
    assign radioPowerGate = st.domain[lpm_pkg::D_RADIO_GATE];
    assign radioDeepSleepClock = st.domain[lpm_pkg::D_RADIO_DSM];
    assign analogOn = st.domain[lpm_pkg::D_ANALOG];
    assign lowPowerOscOn = st.domain[lpm_pkg::D_ANALOG];
    assign brownOutOn = st.domain[lpm_pkg::D_BROWNOUT];
    assign padHold = st.domain[lpm_pkg::D_PAD_HOLD];
    assign wakeInterrupt = st.wakeIntr;
    assign wakeReset = st.wakeRst;
    assign irq = st.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    wait_entry_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_LP_RUN && sleepRequest && !deepSleepSelect
        |=> st.mode == lpm_pkg::MODE_LP_WAIT ##1 coreSleep)
        else $error("wait entry wrong");

    wait_resume_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_LP_WAIT && coreInterrupt
        |=> wakeInterrupt && !wakeReset ##1 !coreSleep && !wakeInterrupt)
        else $error("wait resume wrong");

    bias_off_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode inside {lpm_pkg::MODE_LP_WAIT, lpm_pkg::MODE_LP_STOP}
        |=> biasOff == $past(contSync) && flashLowPower)
        else $error("bias or flash control wrong");

    stop_static_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_LP_STOP |=> !lowVoltageDetectOn && wakeSourceRun)
        else $error("low-power stop controls wrong");

    leak_wake_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_LEAK3 && (|wakeHit)
        |=> wakeInterrupt && !wakeReset && st.mode == lpm_pkg::MODE_LP_RUN)
        else $error("leakage stop wake wrong");

    partial_ram_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_LEAK2
        |=> sramPartialPower && !sramFullPower && sramPortion32k == $past(st.portion32k))
        else $error("partial ram wrong");

    deep_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode inside {lpm_pkg::MODE_DEEP3, lpm_pkg::MODE_DEEP2} && (|wakeHit)
        |=> wakeReset && !wakeInterrupt)
        else $error("deep stop wake reset wrong");

    radio_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_DEEP1 |=> radioPowerGate && !radioRetain && !sramPartialPower)
        else $error("radio gate wrong");

    buck_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_LP_RUN && sleepRequest && deepSleepSelect
        && st.target[2:1] == 2'b11 && !bypassSync
        |=> st.mode == lpm_pkg::MODE_LP_RUN && st.irqStat[lpm_pkg::EV_REFUSE])
        else $error("deep stop 0 under buck not refused");

    pin_only_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_DEEP0N && !(wakeSync[lpm_pkg::WAKE_PIN]
        && st.wakeEn[lpm_pkg::WAKE_PIN])
        |=> !wakeReset && !analogOn && padHold && !brownOutOn)
        else $error("deep stop 0 controls wrong");

    brown_out_a: assert property (@(posedge clk) disable iff (!nrst)
        st.mode == lpm_pkg::MODE_DEEP0B |=> brownOutOn && radioPowerGate)
        else $error("brown-out variant wrong");

endmodule : lpm_controller

// [verification/lpm_core_model.sv]
/*
 * Behavioural model of the core and the wake-up sources around the controller.
 * Assumes the bench commands it with one-cycle go pulses on clk.
 */
`timescale 1ns/1ps
module lpm_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench commands
    input wire logic sleepGo,
    input wire logic deepGo,
    input wire logic wakeGo,
    // Controller answers
    input wire logic wakeInterrupt,
    input wire logic wakeReset,
    // Core and wake pins
    output logic sleepRequest,
    output logic deepSleepSelect,
    output logic coreInterrupt,
    output logic [lpm_pkg::NWAKE-1:0] wakeSource
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleepRequest <= 1'b0;
            deepSleepSelect <= 1'b0;
            coreInterrupt <= 1'b0;
            wakeSource <= 5'h00;
        end else begin
            // One-cycle sleep pulse with its select
            sleepRequest <= sleepGo;
            deepSleepSelect <= deepGo;
            // Hold interrupt and pin until the controller answers
            if (wakeInterrupt || wakeReset) begin
                coreInterrupt <= 1'b0;
                wakeSource <= 5'h00;
            end else if (wakeGo) begin
                coreInterrupt <= 1'b1;
                wakeSource <= 5'h01;
            end
        end
    end
endmodule : lpm_core_model

// [verification/testbench.sv]
/*
 * Self-checking bench for the low-power mode controller.
 * Assumes the core model drives sleep and wake; bench drives registers.
 */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic sleepGo = 1'b0, deepGo = 1'b0, wakeGo = 1'b0, byp = 1'b1, cont = 1'b1;
    logic sleepRequest, deepSleepSelect, coreInterrupt, wakeInterrupt, wakeReset, irq;
    logic [4:0] wakeSource;
    wire [16:0] dom;
    logic [16:0] expDom;
    int bad_count = 0, n_compared = 0, k;
    always #50 clk = ~clk;
    lpm_core_model lpm_core_model_inst (.clk(clk), .nrst(nrst), .sleepGo(sleepGo),
        .deepGo(deepGo), .wakeGo(wakeGo), .wakeInterrupt(wakeInterrupt),
        .wakeReset(wakeReset), .sleepRequest(sleepRequest),
        .deepSleepSelect(deepSleepSelect), .coreInterrupt(coreInterrupt),
        .wakeSource(wakeSource));
    lpm_controller lpm_controller_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .sleepRequest(sleepRequest), .deepSleepSelect(deepSleepSelect),
        .coreInterrupt(coreInterrupt), .wakeSource(wakeSource), .converterBypass(byp),
        .converterContinuous(cont), .coreSleep(dom[15]), .biasOff(dom[14]),
        .flashLowPower(dom[13]), .lowVoltageDetectOn(dom[12]), .wakeUnitOn(dom[11]),
        .wakeSourceRun(dom[10]), .sramFullPower(dom[9]), .sramPartialPower(dom[8]),
        .sramPortion32k(dom[7]), .regFilePower(dom[6]), .radioRetain(dom[5]),
        .radioPowerGate(dom[4]), .radioDeepSleepClock(dom[3]), .analogOn(dom[2]),
        .lowPowerOscOn(dom[1]), .brownOutOn(dom[0]), .padHold(dom[16]),
        .wakeInterrupt(wakeInterrupt),
        .wakeReset(wakeReset), .irq(irq));

    // ************************************************************
    // Expected domain controls per mode code
    // ************************************************************
    function automatic logic [16:0] exp_dom(input int m, input logic c, input logic p);
        logic lo;
        lo = (m <= 2);
        return {m >= 8, m != 0, c && lo, lo, 1'b0, !lo, m < 8, m <= 3 || m == 5, m <= 6,
            p && (m == 4 || m == 6), 1'b1, m >= 3 && m <= 6, m >= 7, m >= 3 && m <= 6,
            m < 8, m < 8, m != 9};
    endfunction : exp_dom

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk(regRdata, exp);
    endtask : rd
    task automatic pulse_go(input logic deep, input logic wake);
        @(posedge clk);
        sleepGo <= !wake;
        deepGo <= deep;
        wakeGo <= wake;
        @(posedge clk);
        sleepGo <= 1'b0;
        wakeGo <= 1'b0;
    endtask : pulse_go
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    initial begin
        #(100 * 20000);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, unmapped and read-only places
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h08, 32'hf);
        rd(8'h08, 32'h30);
        chk(dom, exp_dom(0, 1'b1, 1'b0));
        wr(8'h04, 32'h1f);
        wr(8'h14, 32'h1);
        // Wait mode, then every stop target
        for (int i = 0; i < 9; i++) begin
            if (i > 0) wr(8'h00, (i - 1) | (((i >> 1) & 1) << 3));
            pulse_go(i > 0, 1'b0);
            k = 0;
            while (dom[15] !== 1'b1 && k < 10) begin
                @(negedge clk);
                k++;
            end
            expDom = exp_dom(i == 0 ? 1 : i + 1, 1'b1, i[1]);
            chk(dom[16:8], expDom[16:8]);
            chk(dom[7:0], expDom[7:0]);
            chk(irq, 1'b1);
            rd(8'h08, 32'h30 | (i == 0 ? 1 : i + 1));
            wr(8'h10, 32'h7);
            @(negedge clk);
            chk(irq, 1'b0);
            pulse_go(1'b0, 1'b1);
            k = 0;
            while (wakeInterrupt !== 1'b1 && wakeReset !== 1'b1 && k < 20) begin
                @(negedge clk);
                k++;
            end
            chk({wakeInterrupt, wakeReset}, i >= 4 ? 2'b01 : 2'b10);
            repeat (2) @(negedge clk);
            chk(dom, exp_dom(0, 1'b1, 1'b0));
        end
        // Deep stop 0 with brown-out (target 6) refused under buck converter
        wr(8'h10, 32'h7);
        byp <= 1'b0;
        wr(8'h14, 32'h4);
        wr(8'h00, 32'h6);
        pulse_go(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        chk({dom[15], irq}, 2'b01);
        rd(8'h08, 32'h20);
        rd(8'h0c, 32'h4);
        wr(8'h10, 32'h4);
        rd(8'h0c, 32'h0);
        final_report();
    end
endmodule : testbench
